// File: src/itg_pkg.sv
// Package for the interval trigger and one-shot interrupt gate.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz clock.
package itg_pkg;
    localparam int AXI_ADDR_W = 6;
    localparam int REG_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_ONESHOT = 8;
    localparam int NUM_WATCH = 4;
    localparam int COUNTER_W = 16;
    localparam int WATCH_LSB = 10;
    localparam logic [AXI_ADDR_W-1:0] ADDR_ONESHOT_EN = 6'h00;
    localparam logic [AXI_ADDR_W-1:0] ADDR_INTERVAL_CTRL = 6'h04;
    localparam logic [AXI_ADDR_W-1:0] ADDR_INTERVAL_FLAGS = 6'h08;
    localparam logic [AXI_ADDR_W-1:0] ADDR_ONESHOT_FLAGS = 6'h0c;
    localparam logic [REG_W-1:0] RESET_ONESHOT_EN = 8'h00;
    localparam logic [REG_W-1:0] RESET_INTERVAL_CTRL = 8'h00;
    localparam int ADC_EN_LSB = 4;
    localparam int IRQ_EN_LSB = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
endpackage

// File: src/interval_trigger_gate.sv
// Interval trigger and one-shot interrupt gate with AXI4-Lite registers.
// Assumes the free-running counter and one-shot flags are synchronous to
// clk_in; one-shot flags are owned by the status logic outside.
//
// Notes on behaviour
// - One enable bit per one-shot counter, H..A
// - One-shot request equals flag AND enable
// - One-shot enables read/write, reset to zero
// - Interval control: upper ADC, lower interrupt enables
// - Interval control cleared on reset or standby
// - ADC enables 7..4 watch counter bits 13..10
// - Counter bit rise AND enable starts ADC
// - ADC enable zero blocks, one permits trigger
// - Interrupt enables 3..0 watch bits 13..10
// - Rise AND enable sets flag, requests interrupt
// - Interrupt enable zero suppresses, one permits
`timescale 1ns/10ps
`default_nettype none
module interval_trigger_gate
    import itg_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic standby_in,
    input wire logic [itg_pkg::COUNTER_W-1:0] chan0_free_counter_low_in,
    input wire logic [itg_pkg::NUM_ONESHOT-1:0] oneshot_flag_in,
    output logic [itg_pkg::NUM_ONESHOT-1:0] oneshot_irq_out,
    output logic [itg_pkg::NUM_WATCH-1:0] adc_start_out,
    output logic [itg_pkg::NUM_WATCH-1:0] interval_flag_out,
    output logic interval_irq_out,
    input wire logic [itg_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [itg_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [itg_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [itg_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import itg_pkg::*;

    // Elaboration-time guard: the watched bits must sit inside the counter
    if (WATCH_LSB + NUM_WATCH > COUNTER_W) begin : g_bad_width
        $error("Watched counter bits exceed counter width");
    end

    function automatic logic addr_known(input logic [AXI_ADDR_W-1:0] a);
        addr_known = (a == ADDR_ONESHOT_EN) || (a == ADDR_INTERVAL_CTRL) ||
            (a == ADDR_INTERVAL_FLAGS) || (a == ADDR_ONESHOT_FLAGS);
    endfunction

    logic [REG_W-1:0] oneshot_irq_enable;
    logic [REG_W-1:0] interval_trigger_control;
    logic [NUM_WATCH-1:0] watch_prev;
    logic [NUM_WATCH-1:0] watch_rise;
    logic [NUM_WATCH-1:0] interval_flag;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic aw_held;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic wr_ok;
    logic [NUM_WATCH-1:0] flag_clear;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_ok = addr_known(aw_addr);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            w_held <= 1'b0;
            w_data <= DATA_ZERO;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            oneshot_irq_enable <= RESET_ONESHOT_EN;
        end else if (do_write && w_strb[0] && aw_addr == ADDR_ONESHOT_EN) begin
            oneshot_irq_enable <= w_data[REG_W-1:0];
        end
    end

    // Standby holds the register clear, like a reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || standby_in) begin
            interval_trigger_control <= RESET_INTERVAL_CTRL;
        end else if (do_write && w_strb[0] &&
                     aw_addr == ADDR_INTERVAL_CTRL) begin
            interval_trigger_control <= w_data[REG_W-1:0];
        end
    end

    // Write one to clear interval flags
    assign flag_clear = (do_write && w_strb[0] &&
        aw_addr == ADDR_INTERVAL_FLAGS) ? w_data[NUM_WATCH-1:0] : '0;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            watch_prev <= '0;
        end else begin
            watch_prev <= chan0_free_counter_low_in[WATCH_LSB +: NUM_WATCH];
        end
    end

    assign watch_rise = chan0_free_counter_low_in[WATCH_LSB +: NUM_WATCH]
        & ~watch_prev;

    // Registered pulse, one cycle per rise
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            adc_start_out <= '0;
        end else begin
            adc_start_out <= watch_rise &
                interval_trigger_control[ADC_EN_LSB +: NUM_WATCH];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            interval_flag <= '0;
        end else begin
            interval_flag <= (interval_flag & ~flag_clear) |
                (watch_rise &
                interval_trigger_control[IRQ_EN_LSB +: NUM_WATCH]);
        end
    end

    assign interval_flag_out = interval_flag;
    assign interval_irq_out = |interval_flag;

    // Request follows flag and enable combinationally
    assign oneshot_irq_out = oneshot_flag_in & oneshot_irq_enable;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= DATA_ZERO;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_ONESHOT_EN: begin
                    s_axi_rdata <= {24'h000000, oneshot_irq_enable};
                end
                ADDR_INTERVAL_CTRL: begin
                    s_axi_rdata <= {24'h000000, interval_trigger_control};
                end
                ADDR_INTERVAL_FLAGS: begin
                    s_axi_rdata <= {28'h0000000, interval_flag};
                end
                ADDR_ONESHOT_FLAGS: begin
                    s_axi_rdata <= {24'h000000, oneshot_flag_in};
                end
                default: begin
                    s_axi_rdata <= DATA_ZERO;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: tb/itg_assertions.sv
// Checker on the counter link and request outputs of the trigger gate.
// Assumes one clock, and the counter held low around every reset.
`timescale 1ns/10ps
`default_nettype none
module itg_assertions (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic standby_in,
    input wire logic [15:0] chan0_free_counter_low_in,
    input wire logic [7:0] oneshot_flag_in,
    input wire logic [7:0] oneshot_irq_out,
    input wire logic [3:0] adc_start_out,
    input wire logic [3:0] interval_flag_out,
    input wire logic interval_irq_out,
    input wire logic s_axi_wvalid
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence bit_rose(int b);
        $past(chan0_free_counter_low_in[b])
            && !$past(chan0_free_counter_low_in[b], 2);
    endsequence
    sequence held_standby;
        standby_in [*2];
    endsequence
    for (genvar i = 0; i < 4; i++) begin : g_bit
        adc_cause_a: assert property (
            adc_start_out[i] |-> bit_rose(10 + i)) else $error("stray start");
        flag_cause_a: assert property (
            $rose(interval_flag_out[i]) |-> bit_rose(10 + i))
            else $error("stray interval flag");
        flag_hold_a: assert property (
            $fell(interval_flag_out[i])
            |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2))
            else $error("interval flag lost without write");
    end
    // One cycle only, or the converter starts twice
    adc_pulse_a: assert property (
        |adc_start_out |=> (adc_start_out & $past(adc_start_out)) == 4'h0)
        else $error("start pulse too long");
    irq_or_a: assert property (
        interval_irq_out == (|interval_flag_out)) else $error("bad irq");
    oneshot_mask_a: assert property (
        (oneshot_irq_out & ~oneshot_flag_in) == 8'h00)
        else $error("one-shot request without flag");
    standby_block_a: assert property (
        held_standby |=> adc_start_out == 4'h0
        && (interval_flag_out & ~$past(interval_flag_out)) == 4'h0)
        else $error("event during standby");
    reset_clear_a: assert property (disable iff (1'b0)
        sys_rst_in |=> interval_flag_out == 4'h0 && adc_start_out == 4'h0)
        else $error("outputs not cleared by reset");
endmodule
bind interval_trigger_gate itg_assertions u_itg_assertions (.*);
`default_nettype wire

// File: tb/itg_partner.sv
// Converter trigger input model: records which start lines fired.
// Assumes single-cycle start pulses on clk_in.
`timescale 1ns/10ps
`default_nettype none
module itg_partner (
    input wire logic clk_in,
    input wire logic [3:0] adc_start_in,
    output var logic [3:0] adc_seen_out
);
    initial adc_seen_out = 4'h0;
    always @(posedge clk_in) begin
        adc_seen_out <= adc_seen_out | adc_start_in;
    end
endmodule
`default_nettype wire

// File: tb/interval_trigger_gate_tb.sv
// Self-checking bench for the interval trigger gate.
// Assumes the package register map and the hand-over bus timing.
`timescale 1ns/10ps
`default_nettype none
module interval_trigger_gate_tb;
    import itg_pkg::*;
    logic clk_in = 0, sys_rst_in = 1, standby_in = 0, interval_irq_out;
    logic [15:0] chan0_free_counter_low_in = 0, seed = 16'habb6;
    logic [7:0] oneshot_flag_in = 0, oneshot_irq_out, v;
    logic [3:0] adc_start_out, interval_flag_out, adc_seen;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1, s_axi_awready, s_axi_wready;
    logic s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] notes[$];
    int failures = 0, samples_checked = 0;
    interval_trigger_gate u_interval_trigger_gate (.*);
    itg_partner u_itg_partner (.clk_in(clk_in),
        .adc_start_in(adc_start_out), .adc_seen_out(adc_seen));
    initial forever #2 clk_in = ~clk_in;
    initial begin
        #20000;
        failures++;
        wrap_up;
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic wrap_up;
        if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [33:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d,
            input logic [1:0] r = RESP_OKAY);
        notes.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        do begin
            @(posedge clk_in);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while ((s_axi_awvalid && !s_axi_awready)
            || (s_axi_wvalid && !s_axi_wready));
        while (!s_axi_bvalid) @(posedge clk_in);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] d,
            input logic [1:0] r = RESP_OKAY);
        notes.push_back({r, 24'h0, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge clk_in); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge clk_in); while (!s_axi_rvalid);
    endtask
    // Only one transfer is ever open, so the oldest note is the right one
    always @(posedge clk_in) begin
        if (s_axi_bvalid && s_axi_bready)
            chk("bresp", {s_axi_bresp, 32'h0}, notes.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            chk("rdata", {s_axi_rresp, s_axi_rdata}, notes.pop_front());
    end
    initial begin
        repeat (12) @(posedge clk_in);
        sys_rst_in <= 0;
        @(posedge clk_in);
        rd(ADDR_ONESHOT_EN, 8'h00);
        rd(ADDR_INTERVAL_CTRL, 8'h00);
        repeat (4) begin
            seed = lfsr(seed);
            wr(ADDR_ONESHOT_EN, {24'h0, seed[7:0]});
            rd(ADDR_ONESHOT_EN, seed[7:0]);
            oneshot_flag_in <= seed[15:8];
            @(posedge clk_in);
            chk("oneshot", oneshot_irq_out, seed[15:8] & seed[7:0]);
            rd(ADDR_ONESHOT_FLAGS, seed[15:8]);
        end
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h5a : 8'ha5;
            wr(ADDR_INTERVAL_CTRL, {24'h0, v});
            rd(ADDR_INTERVAL_CTRL, v);
            chan0_free_counter_low_in <= 16'h3c00;
            repeat (3) @(posedge clk_in);
            chk("adc", adc_seen, k ? 4'hf : v[7:4]);
            chk("irq", interval_irq_out, 1'b1);
            chk("flags", interval_flag_out, v[3:0]);
            rd(ADDR_INTERVAL_FLAGS, {4'h0, v[3:0]});
            wr(ADDR_INTERVAL_FLAGS, 32'hf);
            chk("irq", interval_irq_out, 1'b0);
            rd(ADDR_INTERVAL_FLAGS, 8'h00);
            chan0_free_counter_low_in <= 16'h0;
        end
        wr(6'h10, 32'hff, RESP_SLVERR);
        rd(6'h10, 8'h00, RESP_SLVERR);
        standby_in <= 1;
        repeat (2) @(posedge clk_in);
        standby_in <= 0;
        rd(ADDR_INTERVAL_CTRL, 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
